/* File: hdl/sehg_front.sv */
`timescale 1ns/100ps
module sehg_front #(
  parameter int unsigned WRITE_CYCLES = sehg_pkg::WRITE_CYCLES
) (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial link, clocked by the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  // supply detector, asynchronous level
  input wire logic low_supply,
  // serial output pin
  output logic so_out,
  output logic so_oe_n,
  // core status
  output logic write_enable_latch,
  output logic write_in_progress_flag,
  output logic write_disabled_state,
  output logic write_aborted,
  output logic write_commit
);
  // ---------------- link domain ----------------
  // hold state: both edges of hold_n and falling sck handled in one element
  logic hold_state;
  always_ff @(negedge sck or negedge hold_n or posedge hold_n
              or posedge cs_n) begin
    if (cs_n)
      hold_state <= 1'b0;
    else if (!sck)
      hold_state <= !hold_n;
    else
      hold_state <= hold_state;
  end
  // clock high: state is frozen until the next clock fall
  logic hold_eff;
  assign hold_eff = hold_state;

  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [1:0] byte_cnt;
  logic got_write;
  logic [7:0] first_data;
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= '0;
      shreg <= '0;
      opcode <= '0;
      byte_cnt <= '0;
      got_write <= 1'b0;
      first_data <= '0;
    end else if (!hold_eff) begin
      shreg <= {shreg[6:0], si};
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        if (byte_cnt == 2'd0)
          opcode <= {shreg[6:0], si};
        else if (!got_write) begin
          got_write <= 1'b1;
          first_data <= {shreg[6:0], si};
        end
        if (byte_cnt != 2'd3)
          byte_cnt <= byte_cnt + 2'd1;
      end
    end
  end
  // command toggles, launched when select rises at a byte boundary
  logic wren_tgl;
  always_ff @(posedge cs_n or negedge reset_n) begin
    if (!reset_n)
      wren_tgl <= 1'b0;
    else if (bit_cnt == 3'd0 && byte_cnt == 2'd1 &&
             opcode == sehg_pkg::CMD_WREN)
      wren_tgl <= !wren_tgl;
  end

  logic wdis_tgl;
  always_ff @(posedge cs_n or negedge reset_n) begin
    if (!reset_n)
      wdis_tgl <= 1'b0;
    else if (bit_cnt == 3'd0 && byte_cnt == 2'd1 &&
             opcode == sehg_pkg::CMD_WR_DISABLE)
      wdis_tgl <= !wdis_tgl;
  end

  // write request toggle with its word
  logic req_tgl;
  sehg_pkg::sehg_wreq_t req_word;
  always_ff @(posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      req_tgl <= 1'b0;
      req_word <= '0;
    end else if (bit_cnt == 3'd0 && got_write &&
                 (opcode == sehg_pkg::CMD_WRITE ||
                  opcode == sehg_pkg::CMD_SRWR)) begin
      req_word.is_status <= (opcode == sehg_pkg::CMD_SRWR);
      req_word.first_data <= first_data;
      req_tgl <= !req_tgl;
    end
  end

  // output driver, floated on hold or deselect
  logic so_bit;
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n)
      so_bit <= 1'b0;
    else if (!hold_eff)
      so_bit <= shreg[7];
  end

  // ---------------- core domain ----------------
  // pin level synchronisers
  logic [2:0] cs_sync, hold_sync;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cs_sync <= 3'b111;
      hold_sync <= '0;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n};
      hold_sync <= {hold_sync[1:0], hold_eff};
    end
  end

  logic [2:0] low_sync;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      low_sync <= '0;
    else
      low_sync <= {low_sync[1:0], low_supply};
  end

  // toggle synchronisers; third stage only for edge detection
  logic [2:0] req_sync, wren_sync, wdis_sync;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      req_sync <= '0;
      wren_sync <= '0;
      wdis_sync <= '0;
    end else begin
      req_sync <= {req_sync[1:0], req_tgl};
      wren_sync <= {wren_sync[1:0], wren_tgl};
      wdis_sync <= {wdis_sync[1:0], wdis_tgl};
    end
  end

  logic req_ev, wren_ev, wdis_ev, low_now;
  assign req_ev = req_sync[2] ^ req_sync[1];
  assign wren_ev = wren_sync[2] ^ wren_sync[1];
  assign wdis_ev = wdis_sync[2] ^ wdis_sync[1];
  assign low_now = low_sync[1];

  logic [$clog2(WRITE_CYCLES+1)-1:0] wcnt;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
      write_in_progress_flag <= 1'b0;
      write_disabled_state <= 1'b1;
      write_aborted <= 1'b0;
      write_commit <= 1'b0;
      wcnt <= '0;
    end else begin
      write_aborted <= 1'b0;
      write_commit <= 1'b0;
      if (low_now) begin
        write_aborted <= write_in_progress_flag;
        write_in_progress_flag <= 1'b0;
        write_enable_latch <= 1'b0;
        write_disabled_state <= 1'b1;
        wcnt <= '0;
      end else if (write_in_progress_flag) begin
        if (wcnt == '0) begin
          write_in_progress_flag <= 1'b0;
          write_enable_latch <= 1'b0;
          write_disabled_state <= 1'b1;
          write_commit <= 1'b1;
        end else
          wcnt <= wcnt - 1'b1;
      end else if (req_ev && write_enable_latch && cs_sync[1]) begin
        write_in_progress_flag <= 1'b1;
        wcnt <= ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES - 1);
      end else if (wdis_ev) begin
        write_enable_latch <= 1'b0;
        write_disabled_state <= 1'b1;
      end else if (wren_ev) begin
        write_enable_latch <= 1'b1;
        write_disabled_state <= 1'b0;
      end
    end
  end
  // output pin register in core domain from synchronised state
  logic [2:0] sob_sync;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sob_sync <= '0;
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      sob_sync <= {sob_sync[1:0], so_bit};
      so_out <= sob_sync[1];
      so_oe_n <= cs_sync[1] | hold_sync[1];
    end
  end
endmodule : sehg_front

/* File: hdl/sehg_pkg.sv */
package sehg_pkg;
  // serial shift word width and instruction layout
  localparam int unsigned WORD_BITS = 8;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_SRWR = 8'h01;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  // nonvolatile write time, microseconds, and core clock
  localparam int unsigned WRITE_TIME_US = 5000;
  localparam int unsigned REF_CLK_MHZ = 40;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * REF_CLK_MHZ;
  // write request word held in the link domain; only its toggle reaches the core domain
  typedef struct packed {
    logic is_status;
    logic [7:0] first_data;
  } sehg_wreq_t;
  // pin outputs
  typedef struct packed {
    logic so_out;
    logic so_oe_n;
  } sehg_so_t;
endpackage : sehg_pkg

/* File: test/sehg_front_monitor.sv */
`timescale 1ns/100ps
module sehg_front_monitor #(
  parameter int unsigned WRITE_CYCLES = sehg_pkg::WRITE_CYCLES
) (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link pins and supply detector
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic low_supply,
  // outputs
  input wire logic so_oe_n,
  input wire logic write_enable_latch,
  input wire logic write_in_progress_flag,
  input wire logic write_disabled_state,
  input wire logic write_aborted,
  input wire logic write_commit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int unsigned run_cnt;
  always_ff @(posedge ref_clk) begin
    run_cnt <= write_in_progress_flag ? run_cnt + 1 : 0;
  end
  AST_DESEL_FLOAT:
    assert property (cs_n[*4] |-> so_oe_n) else $error("driven deselected");
  AST_HOLD_FLOAT:
    assert property ((!hold_n && !sck)[*4] |-> so_oe_n)
    else $error("driven in hold");
  AST_NEEDS_LATCH:
    assert property ($rose(write_in_progress_flag) |-> $past(write_enable_latch))
    else $error("write without latch");
  AST_NO_WRITE_DESEL:
    assert property (cs_n[*8] |-> !$rose(write_in_progress_flag))
    else $error("write while deselected");
  AST_ABORT_PULSE:
    assert property (low_supply && write_in_progress_flag
      |-> ##[1:4] write_aborted) else $error("no abort");
  AST_LOW_CLEARS:
    assert property (low_supply[*4] |-> !write_enable_latch
      && write_disabled_state) else $error("latch kept at low supply");
  AST_COMMIT_CLEARS:
    assert property (write_commit |=> !write_enable_latch
      && !write_in_progress_flag) else $error("latch kept after write");
  AST_RUN_LENGTH:
    assert property (write_commit |-> run_cnt + 1 >= WRITE_CYCLES
      && run_cnt <= WRITE_CYCLES + 1) else $error("write length wrong");
endmodule : sehg_front_monitor
bind sehg_front sehg_front_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
  .hold_n(hold_n), .low_supply(low_supply), .so_oe_n(so_oe_n),
  .write_enable_latch(write_enable_latch),
  .write_in_progress_flag(write_in_progress_flag),
  .write_disabled_state(write_disabled_state),
  .write_aborted(write_aborted), .write_commit(write_commit));

/* File: test/sehg_front_test.sv */
`timescale 1ns/100ps
module sehg_front_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic low_supply = 1'b0;
  logic sck, cs_n, si, hold_n, so_out, so_oe_n;
  logic latch, busy, disabled, aborted, commit;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  sehg_host u_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n));
  sehg_front #(.WRITE_CYCLES(20)) u_dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .low_supply(low_supply), .so_out(so_out), .so_oe_n(so_oe_n),
    .write_enable_latch(latch), .write_in_progress_flag(busy),
    .write_disabled_state(disabled), .write_aborted(aborted),
    .write_commit(commit));
  task automatic chk(input string nm, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  task automatic send(input logic [7:0] op, input int md);
    u_host.frame({op, 8'hA5}, (op == sehg_pkg::CMD_WREN) ? 8 : 16, md);
    repeat (5) @(negedge ref_clk);
  endtask : send
  task automatic t_hold_write;
    send(sehg_pkg::CMD_WREN, 0);
    chk("latch", 1'b1, latch);
    fork
      send(sehg_pkg::CMD_WRITE, 1);
      begin
        wait (!hold_n);
        chk("oe_n drive", 1'b0, so_oe_n);
        repeat (6) @(negedge ref_clk);
        chk("oe_n hold", 1'b1, so_oe_n);
      end
    join
    chk("busy", 1'b1, busy);
    for (int k = 0; k < 60 && commit !== 1'b1; k++) @(negedge ref_clk);
    chk("commit", 1'b1, commit);
    @(negedge ref_clk);
    chk("latch", 1'b0, latch);
    $display("hold write done");
  endtask : t_hold_write
  task automatic t_hold_desel;
    send(sehg_pkg::CMD_WREN, 0);
    send(sehg_pkg::CMD_WRITE, 2);
    chk("busy", 1'b0, busy);
    $display("hold deselect done");
  endtask : t_hold_desel
  task automatic t_abort;
    send(sehg_pkg::CMD_WREN, 0);
    u_host.frame({sehg_pkg::CMD_SRWR, 8'h0C}, 16, 0);
    repeat (5) @(negedge ref_clk);
    low_supply = 1'b1;
    for (int k = 0; k < 6 && aborted !== 1'b1; k++) @(negedge ref_clk);
    chk("aborted", 1'b1, aborted);
    repeat (4) @(negedge ref_clk);
    low_supply = 1'b0;
    chk("latch", 1'b0, latch);
    chk("disabled", 1'b1, disabled);
    send(sehg_pkg::CMD_WRITE, 0);
    chk("busy", 1'b0, busy);
    $display("abort done");
  endtask : t_abort
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("oe_n", 1'b1, so_oe_n);
    chk("so_out", 1'b0, so_out);
    t_hold_write();
    t_hold_desel();
    t_abort();
    end_of_test();
  end
endmodule : sehg_front_test

/* File: test/sehg_host.sv */
`timescale 1ns/100ps
module sehg_host (
  // host pins
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  // a clean select rise clears the link logic at start
  initial begin
    {sck, cs_n, si, hold_n} = 4'h3;
    #5 cs_n = 1'b1;
  end
  // mode 1 pauses in hold, mode 2 deselects in hold
  task automatic frame(input logic [15:0] w, input int n, input int md);
    cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      si = w[i];
      #15 sck = 1'b1;
      #15 sck = 1'b0;
      if (md != 0 && i == 12) begin
        hold_n = 1'b0;
        repeat (3) begin
          #15 sck = 1'b1;
          #15 sck = 1'b0;
        end
        #210 cs_n = (md == 2);
        hold_n = 1'b1;
        if (md == 2) return;
      end
    end
    #15 cs_n = 1'b1;
    si = ~si;
  endtask : frame
endmodule : sehg_host
